/* rtl/fwp_pkg.sv */
package fwp_pkg;
	// ****************************************
	// array geometry
	// ****************************************
	localparam int ADDR_W = 26;
	localparam int BLK_W = 10;
	localparam int SEC_LSB = 12;
	localparam int BLK_LSB = 16;
	localparam int HALF_BIT = 15;
	localparam int N_BLK = 1024;
	localparam int SEC_PER_BLK = 16;
	localparam logic [BLK_W-1:0] BLK_FIRST = 10'h000;
	localparam logic [BLK_W-1:0] BLK_LAST = 10'h3FF;
	localparam logic [10:0] BLK_SPAN = 11'h400;
	localparam logic [3:0] LVL_NONE = 4'h0;
	localparam logic [3:0] LVL_ALL = 4'hB;
	localparam logic [15:0] SEC_LO_HALF = 16'h00FF;
	localparam logic [15:0] SEC_HI_HALF = 16'hFF00;
	localparam logic [15:0] SEC_ALL = 16'hFFFF;
	// ****************************************
	// command codes and lengths in bytes
	// ****************************************
	localparam logic [7:0] OP_WRITE_ENABLE_CMD = 8'h06;
	localparam logic [7:0] OP_WRDI = 8'h04;
	localparam logic [7:0] OP_WRSR = 8'h01;
	localparam logic [7:0] OP_PP = 8'h02;
	localparam logic [7:0] OP_SE = 8'h20;
	localparam logic [7:0] OP_BE32 = 8'h52;
	localparam logic [7:0] OP_BE64 = 8'hD8;
	localparam logic [7:0] OP_DP = 8'hB9;
	localparam logic [7:0] OP_RDP_RES = 8'hAB;
	localparam logic [7:0] OP_SUSP = 8'hB0;
	localparam logic [7:0] OP_RESM = 8'h30;
	localparam logic [7:0] OP_RST = 8'h99;
	localparam logic [2:0] LEN_NONE = 3'h0;
	localparam logic [2:0] LEN_ONE = 3'h1;
	localparam logic [2:0] LEN_WRSR = 3'h2;
	localparam logic [2:0] LEN_ERASE = 3'h5;
	localparam logic [2:0] LEN_PP_MIN = 3'h6;
	localparam logic [2:0] LEN_SAT = 3'h7;
	// ****************************************
	// status byte of the write-status command
	// ****************************************
	localparam int SR_BP_LO = 2;
	localparam int SR_SRWD = 7;
	// ****************************************
	// apb map
	// ****************************************
	localparam int APB_AW = 8;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STAT = 8'h04;
	localparam logic [7:0] REG_SECLO = 8'h08;
	localparam logic [7:0] REG_SECHI = 8'h0C;
	localparam logic [7:0] REG_BLKLK = 8'h10;
	localparam logic [7:0] REG_LAST = 8'h14;
	localparam int CTRL_TB = 0;
	localparam int CTRL_QIO = 1;
	localparam int CTRL_QCMD = 2;
	localparam int BLKLK_VAL = 16;
	typedef enum logic [1:0] {
		KIND_PROG, KIND_SE4K, KIND_BE32K, KIND_BE64K
	} fwp_kind_t;
	typedef enum logic [1:0] {ST_IDLE, ST_FRAME, ST_DROP} fwp_state_t;
endpackage

/* rtl/fwp_link_if.sv */
`timescale 1ns/1ps
interface fwp_link_if;
	logic [7:0] byte_q;
	logic byte_tgl;
	logic aligned;
	modport link(output byte_q, output byte_tgl, output aligned);
	modport core(input byte_q, input byte_tgl, input aligned);
endinterface

/* rtl/fwp_link.sv */
`timescale 1ns/1ps
module fwp_link
	import fwp_pkg::*;
(
	input wire logic sclk, // serial clock from host
	input wire logic rst_n, // system reset, low active
	input wire logic cs_n, // chip select, low active
	input wire logic si, // serial data in
	fwp_link_if.link lk // byte handoff to core
);
	logic armed_r;
	logic [2:0] bit_r;
	logic [2:0] bit_nxt;
	logic [6:0] sh_r;
	logic [7:0] byte_r;
	logic tgl_r;
	logic algn_r;
	logic last_w;

	// ****************************************
	// bit counting on the serial clock
	// ****************************************
	// first edge of a frame counts as bit one
	assign bit_nxt = armed_r ? 3'(bit_r + 3'h1) : 3'h1;
	assign last_w = armed_r && (bit_r == 3'h7);

	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			armed_r <= 1'b0;
		end else begin
			armed_r <= 1'b1;
		end
	end

	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			bit_r <= 3'h0;
			sh_r <= 7'h00;
			byte_r <= 8'h00;
			tgl_r <= 1'b0;
			algn_r <= 1'b1;
		end else begin
			bit_r <= bit_nxt;
			sh_r <= {sh_r[5:0], si};
			algn_r <= (bit_nxt == 3'h0);
			if (last_w) begin
				byte_r <= {sh_r, si};
				tgl_r <= ~tgl_r;
			end
		end
	end

	assign lk.byte_q = byte_r;
	assign lk.byte_tgl = tgl_r;
	assign lk.aligned = algn_r;
endmodule // fwp_link

/* rtl/fwp_top.sv */
`timescale 1ns/1ps
// Operation
// - after reset the command machine sits in standby, nothing pending
// - array changes only after a complete, valid command frame
// - a command acts only if its length is whole bytes
// - data-changing commands need the write enable latch set first
// - in deep power-down only release, signature, suspend, resume, reset pass
// - software protect: level bits and top/bottom select make region read-only
// - hardware protect: pin low with srwd freezes level bits and srwd
// - four-wire or quad command mode disables hardware protect
// - 4K sectors numbered from address zero, 16384 sectors
// - 1024 blocks of 64K, all but the lowest and highest with individual lock
// - lowest and highest 64K blocks lock per 4K sector
// - bottom select clear: level n protects top 2^(n-1) blocks
// - levels 11 to 15 protect the whole array
// - bottom select set: level n protects lowest 2^(n-1) blocks
// - frame must end on a byte boundary or it is rejected
module fwp_top
	import fwp_pkg::*;
(
	input wire logic clk, // system clock
	input wire logic rst_n, // system reset, low active; sync in top flops, async in fwp_link
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [APB_AW-1:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped
	input wire logic sclk, // serial clock
	input wire logic cs_n, // chip select, low active
	input wire logic si, // serial data in
	input wire logic write_protect_pin_n, // protect pin, low active
	output logic arr_we, // array operation start pulse
	output logic arr_blk, // operation blocked pulse
	output logic [1:0] arr_kind, // kind of last operation
	output logic [ADDR_W-1:0] arr_addr, // address of last operation
	output logic cmd_refused // refused frame pulse
);
	// ****************************************
	// link crossing
	// ****************************************
	fwp_link_if lk_if();
	fwp_link u_link (
		.sclk(sclk),
		.rst_n(rst_n),
		.cs_n(cs_n),
		.si(si),
		.lk(lk_if.link)
	);
	logic cs_s1, cs_s2, cs_s3, cs_s4;
	logic tg_s1, tg_s2, tg_s3;
	logic al_s1, al_s2;
	logic wp_s1, wp_s2;
	logic byte_ev, cs_fall, cs_rise;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			{cs_s1, cs_s2, cs_s3, cs_s4} <= 4'hF;
			{tg_s1, tg_s2, tg_s3} <= 3'h0;
			{al_s1, al_s2} <= 2'h3;
			{wp_s1, wp_s2} <= 2'h3;
		end else begin
			{cs_s1, cs_s2, cs_s3, cs_s4} <= {cs_n, cs_s1, cs_s2, cs_s3};
			{tg_s1, tg_s2, tg_s3} <= {lk_if.byte_tgl, tg_s1, tg_s2};
			{al_s1, al_s2} <= {lk_if.aligned, al_s1};
			{wp_s1, wp_s2} <= {write_protect_pin_n, wp_s1};
		end
	end
	// select seen one stage later, so the last byte lands first
	assign byte_ev = tg_s2 ^ tg_s3;
	assign cs_fall = !cs_s3 && cs_s4;
	assign cs_rise = cs_s3 && !cs_s4;

	// ****************************************
	// command decode helpers
	// ****************************************
	function automatic logic [2:0] need_len(input logic [7:0] op);
		case (op)
			OP_WRITE_ENABLE_CMD, OP_WRDI, OP_DP, OP_RDP_RES: need_len = LEN_ONE;
			OP_SUSP, OP_RESM, OP_RST: need_len = LEN_ONE;
			OP_WRSR: need_len = LEN_WRSR;
			OP_SE, OP_BE32, OP_BE64: need_len = LEN_ERASE;
			OP_PP: need_len = LEN_PP_MIN;
			default: need_len = LEN_NONE;
		endcase
	endfunction
	function automatic logic is_arr(input logic [7:0] op);
		is_arr = (op == OP_PP) || (op == OP_SE) ||
			(op == OP_BE32) || (op == OP_BE64);
	endfunction
	function automatic logic dpd_ok(input logic [7:0] op);
		dpd_ok = (op == OP_RDP_RES) || (op == OP_SUSP) ||
			(op == OP_RESM) || (op == OP_RST);
	endfunction
	function automatic fwp_kind_t op_kind(input logic [7:0] op);
		case (op)
			OP_SE: op_kind = KIND_SE4K;
			OP_BE32: op_kind = KIND_BE32K;
			OP_BE64: op_kind = KIND_BE64K;
			default: op_kind = KIND_PROG;
		endcase
	endfunction
	// sectors of one 64K block touched by an operation
	function automatic logic [15:0] sec_mask(input fwp_kind_t k,
		input logic [3:0] sec, input logic half);
		case (k)
			KIND_BE64K: sec_mask = SEC_ALL;
			KIND_BE32K: sec_mask = half ? SEC_HI_HALF : SEC_LO_HALF;
			default: sec_mask = 16'h0001 << sec;
		endcase
	endfunction

	// ****************************************
	// frame collection
	// ****************************************
	fwp_state_t st_r, st_nxt;
	logic [2:0] nb_r, nb_nxt;
	logic [7:0] op_r;
	logic [31:0] addr_r;
	logic [7:0] first_w;
	logic first_ok, dpd_r;
	assign first_w = lk_if.byte_q;
	assign first_ok = (need_len(first_w) != LEN_NONE) &&
		(!dpd_r || dpd_ok(first_w));
	assign nb_nxt = (nb_r == LEN_SAT) ? nb_r : 3'(nb_r + 3'h1);
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			ST_IDLE: begin
				if (cs_fall) begin
					st_nxt = ST_FRAME;
				end
			end
			ST_FRAME: begin
				if (cs_rise) begin
					st_nxt = ST_IDLE;
				end else if (byte_ev && nb_r == 3'h0 && !first_ok) begin
					st_nxt = ST_DROP;
				end
			end
			ST_DROP: begin
				if (cs_rise) begin
					st_nxt = ST_IDLE;
				end
			end
			default: st_nxt = ST_IDLE;
		endcase
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_r <= ST_IDLE;
			nb_r <= 3'h0;
			op_r <= 8'h00;
			addr_r <= 32'h0000_0000;
		end else begin
			st_r <= st_nxt;
			if (cs_fall) begin
				nb_r <= 3'h0;
			end else if (byte_ev && st_r == ST_FRAME) begin
				nb_r <= nb_nxt;
				if (nb_r == 3'h0) begin
					op_r <= first_w;
				end else if (nb_r < LEN_ERASE) begin
					addr_r <= {addr_r[23:0], first_w};
				end
			end
		end
	end

	// ****************************************
	// frame end: check and execute
	// ****************************************
	logic len_ok, exec_w, acc_w, refuse_w, go_arr, go_wrsr;
	logic wel_r, srwd_r, tb_r, qio_r, qcmd_r;
	logic [3:0] bp_r;
	logic hpm_w, prot_w;
	fwp_kind_t kind_w;
	assign len_ok = (op_r == OP_PP) ? (nb_r >= LEN_PP_MIN) :
		(need_len(op_r) != LEN_NONE && nb_r == need_len(op_r));
	// only a full frame closed on a byte edge acts
	assign exec_w = cs_rise && st_r == ST_FRAME && al_s2 && len_ok;
	assign acc_w = exec_w &&
		(wel_r || !(is_arr(op_r) || op_r == OP_WRSR));
	assign refuse_w = cs_rise && st_r != ST_IDLE && !acc_w;
	assign go_arr = acc_w && is_arr(op_r);
	assign go_wrsr = acc_w && op_r == OP_WRSR;
	assign kind_w = op_kind(op_r);
	assign hpm_w = srwd_r && !wp_s2 && !(qio_r || qcmd_r);

	// ****************************************
	// protection map
	// ****************************************
	logic [BLK_W-1:0] blk_w;
	logic [3:0] sec_w;
	logic [10:0] cnt_w;
	logic spm_hit_w, lock_hit_w;
	logic [15:0] mask_w;
	logic [N_BLK-1:0] blk_lock_r;
	logic [15:0] seclo_r, sechi_r;
	// 64K block and 4K sector index straight from the address
	assign blk_w = addr_r[ADDR_W-1:BLK_LSB];
	assign sec_w = addr_r[BLK_LSB-1:SEC_LSB];
	assign cnt_w = (bp_r == LVL_NONE) ? 11'h000 :
		11'h001 << (bp_r - 4'h1);
	assign spm_hit_w = (bp_r >= LVL_ALL) ||
		(bp_r != LVL_NONE && (tb_r ?
		({1'b0, blk_w} < cnt_w) :
		({1'b0, blk_w} >= 11'(BLK_SPAN - cnt_w))));
	assign mask_w = sec_mask(kind_w, sec_w, addr_r[HALF_BIT]);
	assign lock_hit_w = (blk_w == BLK_FIRST) ? |(seclo_r & mask_w) :
		(blk_w == BLK_LAST) ? |(sechi_r & mask_w) :
		blk_lock_r[blk_w];
	assign prot_w = spm_hit_w || lock_hit_w;

	// ****************************************
	// status state
	// ****************************************
	logic wel_nxt, dpd_nxt, srwd_nxt, lblk_r, lref_r;
	logic [3:0] bp_nxt;
	assign wel_nxt = (acc_w && op_r == OP_WRITE_ENABLE_CMD) ? 1'b1 :
		(acc_w && (op_r == OP_WRDI || op_r == OP_RST ||
		go_arr || go_wrsr)) ? 1'b0 : wel_r;
	assign dpd_nxt = (acc_w && op_r == OP_DP) ? 1'b1 :
		(acc_w && (op_r == OP_RDP_RES || op_r == OP_RST)) ? 1'b0 :
		dpd_r;
	assign bp_nxt = (go_wrsr && !hpm_w) ?
		addr_r[SR_BP_LO+:4] : bp_r;
	assign srwd_nxt = (go_wrsr && !hpm_w) ? addr_r[SR_SRWD] : srwd_r;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wel_r <= 1'b0;
			dpd_r <= 1'b0;
			bp_r <= LVL_NONE;
			srwd_r <= 1'b0;
			arr_we <= 1'b0;
			arr_blk <= 1'b0;
			arr_kind <= KIND_PROG;
			arr_addr <= '0;
			cmd_refused <= 1'b0;
			lblk_r <= 1'b0;
			lref_r <= 1'b0;
		end else begin
			wel_r <= wel_nxt;
			dpd_r <= dpd_nxt;
			bp_r <= bp_nxt;
			srwd_r <= srwd_nxt;
			arr_we <= go_arr && !prot_w;
			arr_blk <= go_arr && prot_w;
			cmd_refused <= refuse_w;
			if (go_arr) begin
				arr_kind <= kind_w;
				arr_addr <= addr_r[ADDR_W-1:0];
				lblk_r <= prot_w;
			end
			if (cs_rise && st_r != ST_IDLE) begin
				lref_r <= refuse_w;
			end
		end
	end

	// ****************************************
	// apb slave, one wait state
	// ****************************************
	logic acc_ph, wr_w, hit_w;
	logic [BLK_W-1:0] bidx_r;
	logic [31:0] rdata_w;

	assign acc_ph = psel && penable && !pready;
	assign wr_w = psel && penable && pready && pwrite;
	assign hit_w = (paddr == REG_CTRL) || (paddr == REG_STAT) ||
		(paddr == REG_SECLO) || (paddr == REG_SECHI) ||
		(paddr == REG_BLKLK) || (paddr == REG_LAST);
	assign rdata_w =
		(paddr == REG_CTRL) ? {29'h0, qcmd_r, qio_r, tb_r} :
		(paddr == REG_STAT) ? {23'h0, st_r != ST_IDLE, hpm_w,
			dpd_r, srwd_r, bp_r, wel_r} :
		(paddr == REG_SECLO) ? {16'h0, seclo_r} :
		(paddr == REG_SECHI) ? {16'h0, sechi_r} :
		(paddr == REG_BLKLK) ? {15'h0, blk_lock_r[bidx_r],
			6'h00, bidx_r} :
		(paddr == REG_LAST) ? {2'h0, lref_r, lblk_r,
			arr_kind, arr_addr} : 32'h0000_0000;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= acc_ph;
			pslverr <= acc_ph && !hit_w;
			prdata <= (acc_ph && !pwrite) ? rdata_w : 32'h0000_0000;
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tb_r <= 1'b0;
			qio_r <= 1'b0;
			qcmd_r <= 1'b0;
			seclo_r <= 16'h0000;
			sechi_r <= 16'h0000;
			blk_lock_r <= '0;
			bidx_r <= BLK_FIRST;
		end else if (wr_w) begin
			if (paddr == REG_CTRL) begin
				tb_r <= pwdata[CTRL_TB];
				qio_r <= pwdata[CTRL_QIO];
				qcmd_r <= pwdata[CTRL_QCMD];
			end
			if (paddr == REG_SECLO) begin
				seclo_r <= pwdata[15:0];
			end
			if (paddr == REG_SECHI) begin
				sechi_r <= pwdata[15:0];
			end
			if (paddr == REG_BLKLK) begin
				bidx_r <= pwdata[BLK_W-1:0];
				blk_lock_r[pwdata[BLK_W-1:0]] <= pwdata[BLKLK_VAL];
			end
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	AST_STANDBY_AT_START: assert property (
		$past(rst_n) == 1'b0 |-> st_r == ST_IDLE && !wel_r && !arr_we)
		else $error("not in standby after reset");
	AST_WRITE_ONLY_AT_END: assert property (
		arr_we |-> $past(cs_rise) && $past(st_r) == ST_FRAME)
		else $error("array write outside frame end");
	AST_ODD_BITS_NO_ACT: assert property (
		cs_rise && !al_s2 |=> !arr_we && !arr_blk && cmd_refused)
		else $error("unaligned frame acted on");
	AST_WEL_NEEDED: assert property (
		arr_we |-> $past(wel_r) ##1 !wel_r)
		else $error("array write without latch or latch kept");
	AST_DPD_FILTER: assert property (
		arr_we |-> !$past(dpd_r))
		else $error("array write in deep power-down");
	AST_PROT_NO_WRITE: assert property (
		$past(go_arr) && $past(prot_w) |-> arr_blk && !arr_we)
		else $error("protected target written");
	AST_HPM_FREEZE: assert property (
		hpm_w |=> $stable(bp_r) && $stable(srwd_r))
		else $error("level bits changed under hardware protect");
	AST_QUAD_NO_HPM: assert property (
		(qio_r || qcmd_r) |-> !hpm_w)
		else $error("hardware protect in quad mode");
	AST_TOP_ONE_BLOCK: assert property (
		bp_r == 4'h1 && !tb_r |-> spm_hit_w == (blk_w == BLK_LAST))
		else $error("level one top region wrong");
	AST_BOT_HALF: assert property (
		bp_r == 4'hA && tb_r |-> spm_hit_w == !blk_w[BLK_W-1])
		else $error("level ten bottom region wrong");
	AST_ALL_LEVELS: assert property (
		bp_r >= LVL_ALL |-> spm_hit_w)
		else $error("high level leaves area open");
endmodule // fwp_top

/* bench/fwp_host.sv */
`timescale 1ns/1ps
// ****************************************
// serial host model, clock stands still between frames
// ****************************************
module fwp_host (
	output logic sclk, // serial clock, low when idle
	output logic cs_n, // chip select, low active
	output logic si // serial data out to device
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end
	// msb-first frame of nb bits; nb not a multiple of 8 ends mid-byte
	task automatic frame(input logic [47:0] d, input int nb);
		int i;
		#3 cs_n = 1'b0;
		for (i = 0; i < nb; i++) begin
			si = d[47-i];
			#16 sclk = 1'b1;
			#16 sclk = 1'b0;
		end
		#40 cs_n = 1'b1; // caller picks byte or off-byte end
		si = ~si;
		#200;
	endtask
endmodule // fwp_host

/* bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	import fwp_pkg::*;
	localparam logic [2:0] E_NO = 3'h0;
	localparam logic [2:0] E_WE = 3'h1;
	localparam logic [2:0] E_BL = 3'h2;
	localparam logic [2:0] E_RF = 3'h4;
	logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, write_protect_pin_n = 1'b1;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, sclk, cs_n, si, arr_we, arr_blk, cmd_refused;
	logic [1:0] arr_kind;
	logic [ADDR_W-1:0] arr_addr;
	int n_errors = 0, checks = 0, n_we = 0, n_bl = 0, n_rf = 0;
	fwp_top dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sclk(sclk), .cs_n(cs_n),
		.si(si), .write_protect_pin_n(write_protect_pin_n),
		.arr_we(arr_we), .arr_blk(arr_blk), .arr_kind(arr_kind),
		.arr_addr(arr_addr), .cmd_refused(cmd_refused));
	fwp_host host (.sclk(sclk), .cs_n(cs_n), .si(si));
	always #10 clk = ~clk;
	always @(posedge clk) begin
		if (arr_we === 1'b1)
			n_we++;
		if (arr_blk === 1'b1)
			n_bl++;
		if (cmd_refused === 1'b1)
			n_rf++;
	end
	// ****************************************
	// shared tasks
	// ****************************************
	task automatic complete_run();
		$display("n_errors=%0d checks=%0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic er);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		for (k = 0; k < 16; k++) begin
			@(posedge clk);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k == 16) begin
			n_errors++;
			complete_run();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		logic r;
		apb(1'b1, a, d, x, r);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic r;
		apb(1'b0, a, 32'h0, d, r);
		chk({r, d[30:0]}, {1'b0, e[30:0]});
	endtask
	task automatic fr(input logic [47:0] d, input int nb, input logic [2:0] e);
		int w0, b0, r0;
		w0 = n_we;
		b0 = n_bl;
		r0 = n_rf;
		host.frame(d, nb);
		chk({29'h0, n_rf != r0, n_bl != b0, n_we != w0}, {29'h0, e});
	endtask
	task automatic cmd1(input logic [7:0] op, input logic [2:0] e);
		fr({op, 40'h0}, 8, e);
	endtask
	task automatic wen();
		cmd1(OP_WRITE_ENABLE_CMD, E_NO);
	endtask
	task automatic wrsr(input logic [7:0] s);
		wen();
		fr({OP_WRSR, s, 32'h0}, 16, E_NO);
	endtask
	task automatic erase(input logic [7:0] op, input logic [1:0] k,
		input logic [31:0] a, input logic [2:0] e);
		wen();
		fr({op, a, 8'h00}, 40, e);
		chk({arr_kind, arr_addr}, {k, a[25:0]});
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset();
		logic [31:0] d;
		logic r;
		rdc(REG_STAT, 32'h0);
		chk({1'b0, arr_addr, arr_kind, arr_we, arr_blk, cmd_refused}, 0);
		apb(1'b0, 8'h18, 32'h0, d, r);
		chk({31'h0, r}, 32'h1);
		chk(d, 32'h0);
		wr(REG_STAT, 32'hFFFFFFFF);
		rdc(REG_STAT, 32'h0);
	endtask
	task automatic t_wel();
		fr({OP_SE, 32'h00100000, 8'h00}, 40, E_RF);
		wen();
		rdc(REG_STAT, 32'h1);
		cmd1(OP_WRDI, E_NO);
		rdc(REG_STAT, 32'h0);
	endtask
	task automatic t_frame();
		wen();
		fr({OP_SE, 32'h03FFF000, 8'h00}, 39, E_RF);
		fr({OP_WRITE_ENABLE_CMD, 40'h0}, 9, E_RF);
		fr({OP_SE, 32'h03FFF000, 8'h00}, 32, E_RF);
		rdc(REG_STAT, 32'h1);
		fr({OP_SE, 32'h03FFF000, 8'h00}, 40, E_WE);
		chk({arr_kind, arr_addr}, {2'h1, 26'h3FFF000});
		rdc(REG_STAT, 32'h0);
	endtask
	task automatic t_levels();
		int tb, n, sz, p, u;
		for (tb = 0; tb < 2; tb++) begin
			wr(REG_CTRL, tb);
			for (n = 0; n < 16; n++) begin
				wrsr({2'b00, n[3:0], 2'b00});
				sz = (n == 0) ? 0 : (n >= 11) ? 1024 : 1 << (n - 1);
				p = (tb == 0) ? 1024 - sz : sz - 1;
				u = (tb == 0) ? 1023 - sz : sz;
				if (sz > 0)
					erase(OP_BE64, 2'h3, p << 16, E_BL);
				if (sz < 1024)
					erase(OP_BE64, 2'h3, {6'h0, u[9:0], 16'h0}, E_WE);
			end
		end
		wrsr(8'h00);
		wr(REG_CTRL, 32'h0);
	endtask
	task automatic t_hpm();
		wrsr(8'h88);
		rdc(REG_STAT, 32'h24);
		write_protect_pin_n <= 1'b0;
		repeat (4) @(posedge clk);
		rdc(REG_STAT, 32'hA4);
		wrsr(8'h00);
		rdc(REG_STAT, 32'hA4);
		wr(REG_CTRL, 32'h2);
		rdc(REG_STAT, 32'h24);
		wrsr(8'h00);
		rdc(REG_STAT, 32'h0);
		wr(REG_CTRL, 32'h0);
		wrsr(8'h88);
		wr(REG_CTRL, 32'h4);
		rdc(REG_CTRL, 32'h4);
		wrsr(8'h00);
		rdc(REG_STAT, 32'h0);
		wr(REG_CTRL, 32'h0);
		write_protect_pin_n <= 1'b1;
	endtask
	task automatic t_dp();
		cmd1(OP_DP, E_NO);
		rdc(REG_STAT, 32'h40);
		cmd1(OP_WRITE_ENABLE_CMD, E_RF);
		cmd1(OP_WRDI, E_RF);
		fr({OP_SE, 32'h00200000, 8'h00}, 40, E_RF);
		cmd1(OP_SUSP, E_NO);
		cmd1(OP_RESM, E_NO);
		rdc(REG_STAT, 32'h40);
		cmd1(OP_RDP_RES, E_NO);
		rdc(REG_STAT, 32'h0);
		cmd1(OP_DP, E_NO);
		cmd1(OP_RST, E_NO);
		rdc(REG_STAT, 32'h0);
	endtask
	task automatic t_locks();
		wr(REG_SECLO, 32'h00000008);
		erase(OP_SE, 2'h1, 32'h00003000, E_BL);
		erase(OP_SE, 2'h1, 32'h00004000, E_WE);
		erase(OP_BE32, 2'h2, 32'h00000000, E_BL);
		erase(OP_BE32, 2'h2, 32'h00008000, E_WE);
		wr(REG_SECHI, 32'h00008000);
		erase(OP_SE, 2'h1, 32'h03FFF000, E_BL);
		erase(OP_SE, 2'h1, 32'h03FFE000, E_WE);
		wr(REG_BLKLK, 32'h00010005);
		rdc(REG_BLKLK, 32'h00010005);
		erase(OP_SE, 2'h1, 32'h0005F000, E_BL);
		rdc(REG_LAST, 32'h1405F000);
		erase(OP_BE64, 2'h3, 32'h00060000, E_WE);
		wen();
		fr({OP_PP, 32'h00070010, 8'hA5}, 48, E_WE);
		chk({arr_kind, arr_addr}, {2'h0, 26'h0070010});
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge clk);
		t_reset();
		t_wel();
		t_frame();
		t_levels();
		t_hpm();
		t_dp();
		t_locks();
		complete_run();
	end
endmodule // tb_top
